// *** verilog/acs_pkg.sv ***
// Shared constants and types of the converter channel sequencer control block
package acs_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses on the AXI4-Lite slave)
   // ---------------------------------------------------------------
   localparam logic [3:0]  ACS_OFF_CTRL   = 4'h0;   // Control word, read/write
   localparam logic [3:0]  ACS_OFF_STATUS = 4'h4;   // Status, bit 3 write one to clear
   localparam logic [3:0]  ACS_OFF_RESULT = 4'h8;   // Last conversion result, read only
   localparam logic [11:0] ACS_CTRL_RESET = 12'h000;
   localparam int          ACS_STAT_UNSAFE_BIT = 3;

   // ---------------------------------------------------------------
   // Conversion timing, counted in conversion-clock edges
   // ---------------------------------------------------------------
   localparam int         ACS_CONV_PERIODS = 13;                   // Full periods per conversion
   localparam logic [4:0] ACS_HALF_ALL     = 5'(2 * ACS_CONV_PERIODS); // 26 edges
   localparam logic [4:0] ACS_HALF_LATE    = 5'(2 * ACS_CONV_PERIODS - 1); // 12.5 periods

   // ---------------------------------------------------------------
   // Control word fields, msb first (bit 11 down to bit 0)
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] power_sel;      // Power mode, bits 11:10
      logic       output_twos;    // Output coding, bit 9
      logic       ref_internal;   // Reference select, bit 8
      logic       unused_zero;    // Bit 7
      logic [1:0] channel_select; // Channel address, bits 6:5
      logic [1:0] input_config;   // Bit 4 is input_config_hi, bit 3 input_config_lo
      logic [1:0] sequence_ctl;   // Bit 2 sequence_ctl_hi, bit 1 sequence_ctl_lo
      logic       range_double;   // Bit 0
   } acs_ctrl_t;

   localparam logic [1:0] ACS_CFG_SINGLE = 2'h0;  // {hi,lo} = 00
   localparam logic [1:0] ACS_CFG_DIFF   = 2'h2;  // hi=1, lo=0
   localparam logic [1:0] ACS_CFG_PSEUDO = 2'h1;  // hi=0, lo=1
   localparam logic [1:0] ACS_SEQ_OFF    = 2'h0;
   localparam logic [1:0] ACS_SEQ_ON     = 2'h3;
   localparam logic [1:0] ACS_PM_NORMAL  = 2'h0;
   localparam logic [1:0] ACS_PM_AUTOOFF = 2'h1;
   localparam logic [1:0] ACS_PM_STANDBY = 2'h2;
   localparam logic [1:0] ACS_PM_FULLOFF = 2'h3;

   // Analog input switch selection travelling to the input multiplexer
   typedef struct packed {
      logic [1:0] pos_sel;   // Input routed to the positive side
      logic [1:0] neg_sel;   // Input routed to the negative side
      logic       neg_gnd;   // Negative side tied to analog_ground
      logic       pseudo;    // Pseudo-differential operation
   } acs_mux_t;

   typedef enum logic [1:0] {
      ACS_ST_IDLE = 2'b00,
      ACS_ST_CONV = 2'b01
   } acs_state_t;

endpackage : acs_pkg

// *** verilog/acs_sequencer.sv ***
// Converter control, channel sequencer and AXI4-Lite register slave
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
module acs_sequencer
   import acs_pkg::*;
#(
   parameter int RES_BITS = 12
) (
   // Clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // AXI4-Lite write channels
   input  wire logic [3:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // AXI4-Lite read channels
   input  wire logic [3:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // Converter pins from the host
   input  wire logic                conversion_clock,
   input  wire logic                convert_start_n,
   // Analog core
   input  wire logic                comp_above,
   output acs_mux_t                 mux_sel,
   output logic                     input_hold,
   output logic [RES_BITS-1:0]      dac_code,
   output logic                     core_pwr_on,
   output logic                     ref_pwr_on
);
   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   if (RES_BITS < 2 || RES_BITS > ACS_CONV_PERIODS - 1) begin : g_bad_res
      $error("RES_BITS must be 2 or more and leave at least one sampling period");
   end
   localparam logic [4:0] FIRST_DEC = 5'(2 * (ACS_CONV_PERIODS - RES_BITS + 1));
   localparam logic [RES_BITS-1:0] TWOS_FLIP = RES_BITS'(1) << (RES_BITS - 1); // Msb only
   // Channel to switch setting; config 11 is never programmed, single-ended is the safe fallback
   function automatic acs_mux_t mux_decode(input logic [1:0] cfg, input logic [1:0] chan);
      acs_mux_t m;
      m.pos_sel = chan;
      m.neg_sel = chan ^ 2'h1;
      m.neg_gnd = (cfg != ACS_CFG_DIFF) && (cfg != ACS_CFG_PSEUDO);
      m.pseudo  = (cfg == ACS_CFG_PSEUDO);
      return m;
   endfunction : mux_decode
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   acs_ctrl_t             ctrl_ff;
   acs_state_t            state_ff;
   acs_mux_t              mux_ff;
   logic [4:0]            half_cnt_ff;
   logic [RES_BITS-1:0]   sar_ff, result_ff, trial_bit;
   logic [1:0]            seq_pos_ff, chan_ff, bresp_ff, rresp_ff, final_pos, seq_step;
   logic [31:0]           rdata_ff;
   logic                  cclk_prev_ff, cst_prev_ff, aborted_ff, blocked_ff, unsafe_ff;
   logic                  awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic                  hold_ff, core_on_ff, ref_on_ff;
   // Edge detection; pins are synchronous to aclk
   logic start_fall, start_rise, cclk_rise, cclk_fall, busy, abort_now, done_now;
   logic wr_take, rd_take, ctrl_wr, seq_wr, stat_wr;
   assign trial_bit  = sar_ff & (~sar_ff + RES_BITS'(1));          // Lowest set bit is on trial
   assign start_fall = cst_prev_ff & ~convert_start_n;
   assign start_rise = ~cst_prev_ff & convert_start_n;
   assign cclk_rise  = ~cclk_prev_ff & conversion_clock;
   assign cclk_fall  = cclk_prev_ff & ~conversion_clock;
   assign busy       = (state_ff == ACS_ST_CONV);
   assign abort_now  = busy && start_fall;
   assign done_now   = busy && !start_fall && (cclk_rise || cclk_fall)
                       && (half_cnt_ff == ACS_HALF_ALL - 5'h1);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cclk_prev_ff <= 1'b0;
         cst_prev_ff  <= 1'b1;
      end else begin
         cclk_prev_ff <= conversion_clock;
         cst_prev_ff  <= convert_start_n;
      end
   end
   // ---------------------------------------------------------------
   // AXI4-Lite slave: address and data taken together, one cycle pulse
   // ---------------------------------------------------------------
   assign wr_take = awready_ff;   // awvalid and wvalid held high by the master meanwhile
   assign rd_take = arready_ff;
   assign ctrl_wr = wr_take && (s_axi_awaddr == ACS_OFF_CTRL);
   assign stat_wr = wr_take && (s_axi_awaddr == ACS_OFF_STATUS);
   assign seq_wr  = ctrl_wr && s_axi_wstrb[0] && (s_axi_wdata[2:1] == ACS_SEQ_ON);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= 2'h0;
      end else begin
         awready_ff <= s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
         wready_ff  <= s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
         if (wr_take) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (ctrl_wr || stat_wr) ? 2'h0 : 2'h2;   // Unmapped gives SLVERR
         end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end
   // Read path; result and status are sampled at the accepting edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rresp_ff   <= 2'h0;
         rdata_ff   <= 32'h0;
      end else begin
         arready_ff <= s_axi_arvalid && !arready_ff && !rvalid_ff;
         if (rd_take) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= 2'h0;
            case (s_axi_araddr)
               ACS_OFF_CTRL:   rdata_ff <= {20'h0, ctrl_ff};
               ACS_OFF_STATUS: rdata_ff <= {22'h0, core_on_ff, ref_on_ff, seq_pos_ff,
                                            chan_ff, unsafe_ff, blocked_ff, aborted_ff, busy};
               ACS_OFF_RESULT: rdata_ff <= 32'(result_ff);
               default: begin
                  rdata_ff <= 32'h0;
                  rresp_ff <= 2'h2;
               end
            endcase
         end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end
   // Control word with byte lanes; lane 1 holds bits 11:8
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_ff <= acs_ctrl_t'(ACS_CTRL_RESET);
      end else if (ctrl_wr) begin
         if (s_axi_wstrb[0]) ctrl_ff[7:0]  <= s_axi_wdata[7:0];
         if (s_axi_wstrb[1]) ctrl_ff[11:8] <= s_axi_wdata[11:8];
      end
   end
   // ---------------------------------------------------------------
   // Abort bookkeeping
   // ---------------------------------------------------------------
   // A late abort leaves the sequencer unsettled until a start rise or clock fall
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aborted_ff <= 1'b0;
         blocked_ff <= 1'b0;
         unsafe_ff  <= 1'b0;
      end else begin
         if (abort_now) aborted_ff <= 1'b1;
         else if (start_fall) aborted_ff <= 1'b0;
         if (abort_now && half_cnt_ff == ACS_HALF_LATE) blocked_ff <= 1'b1;
         else if (start_rise || cclk_fall) blocked_ff <= 1'b0;
         // Set wins over a write-one-to-clear in the same cycle
         if (seq_wr && blocked_ff) unsafe_ff <= 1'b1;
         else if (stat_wr && s_axi_wstrb[0] && s_axi_wdata[ACS_STAT_UNSAFE_BIT])
            unsafe_ff <= 1'b0;
      end
   end
   // ---------------------------------------------------------------
   // Channel selection and sequencer position
   // ---------------------------------------------------------------
   // Differential sequencing walks forward pairs only and ends on the pair's even input
   assign seq_step  = (ctrl_ff.input_config == ACS_CFG_DIFF ||
                       ctrl_ff.input_config == ACS_CFG_PSEUDO) ? 2'h2 : 2'h1;
   assign final_pos = (seq_step == 2'h2) ? {ctrl_ff.channel_select[1], 1'b0}
                                         : ctrl_ff.channel_select;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq_pos_ff <= 2'h0;
         chan_ff    <= 2'h0;
         mux_ff     <= '0;
      end else if (start_fall) begin
         if (ctrl_ff.sequence_ctl == ACS_SEQ_ON) begin
            chan_ff    <= seq_pos_ff;
            mux_ff     <= mux_decode(ctrl_ff.input_config, seq_pos_ff);
            seq_pos_ff <= (seq_pos_ff >= final_pos) ? 2'h0 : seq_pos_ff + seq_step;
         end else begin
            chan_ff <= ctrl_ff.channel_select;
            mux_ff  <= mux_decode(ctrl_ff.input_config, ctrl_ff.channel_select);
         end
      end else if (seq_wr) begin
         seq_pos_ff <= 2'h0;
      end
   end
   // ---------------------------------------------------------------
   // Conversion engine: sample, then one decision per later full period
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff    <= ACS_ST_IDLE;
         half_cnt_ff <= 5'h0;
         sar_ff      <= '0;
         hold_ff     <= 1'b0;
      end else if (start_fall) begin
         // A start while busy aborts and restarts in the same cycle
         state_ff    <= ACS_ST_CONV;
         half_cnt_ff <= 5'h0;
         sar_ff      <= {1'b1, {(RES_BITS-1){1'b0}}};
         hold_ff     <= 1'b1;
      end else if (busy && (cclk_rise || cclk_fall)) begin
         half_cnt_ff <= half_cnt_ff + 5'h1;
         if (half_cnt_ff + 5'h1 >= FIRST_DEC && !half_cnt_ff[0]) begin
            // Keep or drop the trial bit, then try the next lower one
            sar_ff <= (comp_above ? sar_ff : sar_ff & ~trial_bit) | (trial_bit >> 1);
         end
         if (done_now) begin
            state_ff <= ACS_ST_IDLE;
            hold_ff  <= 1'b0;
         end
      end else begin
         case (state_ff)
            ACS_ST_IDLE: hold_ff <= 1'b0;
            ACS_ST_CONV: hold_ff <= 1'b1;
            default:     state_ff <= ACS_ST_IDLE;
         endcase
      end
   end
   // Output coding is applied to the final word only; bit 0 is decided on the last edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_ff <= '0;
      end else if (done_now) begin
         result_ff <= (comp_above ? sar_ff : sar_ff & ~trial_bit)
                      ^ (ctrl_ff.output_twos ? TWOS_FLIP : '0);
      end
   end
   // ---------------------------------------------------------------
   // Power control; automatic modes wake on a start and sleep after it
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_on_ff <= 1'b1;
         ref_on_ff  <= 1'b1;
      end else if (ctrl_ff.power_sel == ACS_PM_FULLOFF) begin
         core_on_ff <= 1'b0;
         ref_on_ff  <= 1'b0;
      end else if (ctrl_ff.power_sel == ACS_PM_NORMAL || start_fall || busy) begin
         core_on_ff <= 1'b1;
         ref_on_ff  <= 1'b1;
      end else begin
         core_on_ff <= 1'b0;
         ref_on_ff  <= (ctrl_ff.power_sel == ACS_PM_STANDBY);
      end
   end
   // Every output straight from a flop
   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_rdata   = rdata_ff;
   assign mux_sel       = mux_ff;
   assign input_hold    = hold_ff;
   assign dac_code      = sar_ff;
   assign core_pwr_on   = core_on_ff;
   assign ref_pwr_on    = ref_on_ff;
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_done_count;
      $fell(busy) && !start_fall |-> $past(half_cnt_ff) == ACS_HALF_ALL - 5'h1;
   endproperty
   a_done_count: assert property (p_done_count) else $error("conversion ended early");
   property p_abort_flag;
      abort_now |=> aborted_ff && busy && half_cnt_ff == 5'h0;
   endproperty
   a_abort_flag: assert property (p_abort_flag) else $error("abort not flagged");
   property p_late_block;
      abort_now && half_cnt_ff == ACS_HALF_LATE && !start_rise |=> blocked_ff;
   endproperty
   a_late_block: assert property (p_late_block) else $error("late abort not blocked");
   property p_unsafe;
      seq_wr && blocked_ff |=> unsafe_ff [*2];
   endproperty
   a_unsafe: assert property (p_unsafe) else $error("unsafe reprogram missed");
   property p_single;
      start_fall && ctrl_ff.input_config == ACS_CFG_SINGLE |=> mux_ff.neg_gnd;
   endproperty
   a_single: assert property (p_single) else $error("single-ended not grounded");
   property p_pairs;
      start_fall && ctrl_ff.input_config == ACS_CFG_DIFF
         |=> !mux_ff.neg_gnd && mux_ff.neg_sel == (mux_ff.pos_sel ^ 2'h1);
   endproperty
   a_pairs: assert property (p_pairs) else $error("wrong differential pair");
   property p_no_inverse;
      start_fall && ctrl_ff.sequence_ctl == ACS_SEQ_ON && seq_step == 2'h2 |=> !chan_ff[0];
   endproperty
   a_no_inverse: assert property (p_no_inverse) else $error("inverse pair sequenced");
   property p_advance;
      start_fall && ctrl_ff.sequence_ctl == ACS_SEQ_ON
         |=> chan_ff == $past(seq_pos_ff) &&
             seq_pos_ff == (($past(seq_pos_ff) >= $past(final_pos)) ? 2'h0
                            : 2'($past(seq_pos_ff) + $past(seq_step)));
   endproperty
   a_advance: assert property (p_advance) else $error("sequence step wrong");
   property p_hold;
      busy |-> hold_ff;
   endproperty
   a_hold: assert property (p_hold) else $error("inputs reconnected during conversion");
endmodule : acs_sequencer

// *** tb/acs_host_model.sv ***
// Host side model: conversion clock, start strobe and comparator
module acs_host_model (
   // Clock
   input  wire logic        aclk,
   // Analog core view
   input  wire logic [11:0] dac_code,
   // Host pins
   output logic             conversion_clock,
   output logic             convert_start_n,
   output logic             comp_above
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] target;
   initial begin
      conversion_clock = 1'b0;
      convert_start_n = 1'b1;
      target = 12'h000;
   end
   // Comparator keeps a trial bit while the held input is not below it
   assign comp_above = (target >= dac_code);
   // Falling strobe starts a conversion and steps the sequence
   task automatic fall(input logic [11:0] t);
      @(posedge aclk);
      convert_start_n <= 1'b0;
      target <= t;
   endtask : fall
   // Rising strobe; also the edge that makes reprogramming safe
   task automatic rise();
      repeat (2) @(posedge aclk);
      convert_start_n <= 1'b1;
   endtask : rise
   // Clock stands still between frames; three cycles a level so each is seen
   task automatic edges(input int n);
      repeat (n) begin
         repeat (3) @(posedge aclk);
         conversion_clock <= ~conversion_clock;
      end
   endtask : edges
endmodule : acs_host_model

// *** tb/adc_channel_sequencer_control_bench.sv ***
// Self-checking bench of the converter sequencer control block
module adc_channel_sequencer_control_bench;
   import acs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        conversion_clock, convert_start_n, comp_above, input_hold;
   logic        core_pwr_on, ref_pwr_on;
   logic [11:0] dac_code, t;
   acs_mux_t    mux_sel;
   logic        cod;
   logic [1:0]  chq [$];
   logic [1:0]  cfgs [3] = '{ACS_CFG_SINGLE, ACS_CFG_DIFF, ACS_CFG_PSEUDO};
   logic [1:0]  pw [4] = '{2'h3, 2'h0, 2'h1, 2'h0};
   int          n_errors = 0, checks_done = 0;
   always #5 aclk = ~aclk;
   acs_sequencer #(.RES_BITS(12)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conversion_clock,
      .convert_start_n, .comp_above, .mux_sel, .input_hold, .dac_code, .core_pwr_on,
      .ref_pwr_on);
   acs_host_model host_u (.aclk, .dac_code, .conversion_clock, .convert_start_n, .comp_above);
   // Verdict and end of run
   task automatic close_out();
      if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Control word, msb first: power, coding, reference, zero, address, config, sequence, range
   function automatic logic [31:0] cw(logic [1:0] pm, logic cd, logic [1:0] ad,
                                      logic [1:0] cf, logic [1:0] sq);
      return {20'h0, pm, cd, 2'h0, ad, cf, sq, 1'b0};
   endfunction : cw
   // Write: address and data offered together, each released when taken
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (k == 40) begin
         n_errors++;
         close_out();
      end
   endtask : axw
   // Read and compare response code and masked data
   task automatic axr(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic [1:0] er);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (k == 40) begin
         n_errors++;
         close_out();
      end
      chk({s_axi_rresp, s_axi_rdata & m}, {er, e});
   endtask : axr
   // One full conversion with input routing checked while the sample is held
   task automatic run(input logic [11:0] v, input logic [1:0] ch, input logic [1:0] cf);
      host_u.fall(v);
      repeat (3) @(posedge aclk);
      chk(input_hold, 1'b1);
      chk({mux_sel.pos_sel, mux_sel.neg_gnd, mux_sel.pseudo, cf == 2'h0 ? 2'h0 : mux_sel.neg_sel},
          {ch, cf == ACS_CFG_SINGLE, cf == ACS_CFG_PSEUDO, cf == 2'h0 ? 2'h0 : ch ^ 2'h1});
      host_u.rise();
      host_u.edges(2 * ACS_CONV_PERIODS);
      repeat (4) @(posedge aclk);
      chk(input_hold, 1'b0);
   endtask : run
   // Main sequence: reset, routing and coding, sequencing, abort handling
   initial begin
      void'($urandom(32'h1456));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      axr(ACS_OFF_CTRL, 32'(ACS_CTRL_RESET), '1, 2'h0);
      axr(4'hc, 32'h0, '1, 2'h2);
      for (int c = 0; c < 3; c++) begin
         for (int a = 0; a < 4; a++) begin
            t = 12'($urandom);
            cod = 1'($urandom);
            axw(ACS_OFF_CTRL, cw(2'(a), cod, 2'(a), cfgs[c], ACS_SEQ_OFF));
            run(t, 2'(a), cfgs[c]);
            chk({core_pwr_on, ref_pwr_on}, pw[a]);
            axr(ACS_OFF_RESULT, {20'h0, t ^ {cod, 11'h0}}, '1, 2'h0);
         end
      end
      // Sequence model: forward channels only in paired modes, restart on each write
      for (int c = 0; c < 2; c++) begin
         chq = {};
         for (int k = 0; k < 4; k++) begin
            if (c == 0 || k % 2 == 0) chq.push_back(2'(k));
         end
         axw(ACS_OFF_CTRL, cw(2'h0, 1'b0, 2'h3, cfgs[c], ACS_SEQ_ON));
         for (int i = 0; i < 6; i++) begin
            run(12'($urandom), chq[i % chq.size()], cfgs[c]);
         end
      end
      // Abort at 12.5 periods, then reprogram before any releasing edge
      host_u.fall(12'h0);
      host_u.rise();
      host_u.edges(2 * ACS_CONV_PERIODS - 1);
      host_u.fall(12'h0);
      repeat (3) @(posedge aclk);
      axw(ACS_OFF_CTRL, cw(2'h0, 1'b0, 2'h3, ACS_CFG_SINGLE, ACS_SEQ_ON));
      axr(ACS_OFF_STATUS, 32'h0a, 32'h0a, 2'h0);
      host_u.rise();
      axw(ACS_OFF_STATUS, 32'h8);
      host_u.edges(2 * ACS_CONV_PERIODS);
      repeat (4) @(posedge aclk);
      axw(ACS_OFF_CTRL, cw(2'h0, 1'b0, 2'h3, ACS_CFG_SINGLE, ACS_SEQ_ON));
      axr(ACS_OFF_STATUS, 32'h0, 32'h0c, 2'h0);
      close_out();
   end
endmodule : adc_channel_sequencer_control_bench
